// File: include/acccr_pkg.sv
package acccr_pkg;

	localparam int N_IN   = 16;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int IRQ_W  = 4;

	// Register offsets, byte addressed as printed
	localparam logic [ADDR_W-1:0] PIN_CTRL_OFS   = 12'h026;
	localparam logic [ADDR_W-1:0] PIN_STATE_OFS  = 12'h028;
	localparam logic [ADDR_W-1:0] TEMP_CTRL_OFS  = 12'h029;
	localparam logic [ADDR_W-1:0] CFG_BASE_OFS   = 12'h030;
	localparam logic [ADDR_W-1:0] CFG_LAST_OFS   = 12'h03F;
	localparam logic [ADDR_W-1:0] CFG_STRIDE     = 12'h001;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 12'h0F0;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFS   = 12'h0F1;

	// Field positions
	localparam int OUT_FN_EN_BIT   = 0;
	localparam int IN_FN_EN_BIT    = 4;
	localparam int GPI_FIELD_LSB   = 4;
	localparam int GPO_FIELD_LSB   = 0;
	localparam int GPO_FIELD_W     = 4;
	localparam int TEMP_EN_BIT     = 0;
	localparam int IRQ_GPI_BIT     = 0;
	localparam int IRQ_HIGH_BIT    = 1;
	localparam int IRQ_LOW_BIT     = 2;
	localparam int IRQ_BAD_PAIR_BIT = 3;

	// Reset values and writable-bit masks
	localparam logic [DATA_W-1:0] PIN_CTRL_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] PIN_STATE_RESET = 8'h00;
	localparam logic [DATA_W-1:0] TEMP_CTRL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] CFG_RESET       = 8'h08;
	localparam logic [DATA_W-1:0] PIN_CTRL_WMASK  = 8'h11;
	localparam logic [DATA_W-1:0] TEMP_CTRL_WMASK = 8'h01;
	localparam logic [DATA_W-1:0] CFG_WMASK       = 8'hFB;
	localparam logic [IRQ_W-1:0]  IRQ_RESET       = 4'h0;

	typedef enum logic [1:0]
	{
		PAIR_REF_GROUND = 2'h0,
		PAIR_COMMON     = 2'h1,
		PAIR_NEIGHBOUR  = 2'h2,
		PAIR_INVALID    = 2'h3
	} acccr_pair_e;

	// Stored per-input configuration, bit 7 down to bit 0
	typedef struct packed
	{
		logic        threshold_detect_enable;
		logic        polarity;
		acccr_pair_e pairing_select;
		logic        hiz_enable;
		logic        reserved;
		logic [1:0]  osr_select;
	} acccr_cfg_s;

	// Effective per-input settings handed to the conversion logic
	typedef struct packed
	{
		logic        threshold_detect_enable;
		logic        polarity;
		acccr_pair_e pairing_select;
		logic        hiz_enable;
		logic [1:0]  osr_select;
	} acccr_chan_s;

	localparam logic [6:0] CHAN_RESET = 7'h04;

endpackage

// File: hdl/acccr_chan_sel.sv
`timescale 1ns/1ps
module acccr_chan_sel
	import acccr_pkg::*;
(
	input  wire acccr_cfg_s  own_cfg_in,
	input  wire acccr_cfg_s  base_cfg_in,
	input  wire logic        advanced_seq_in,
	output      acccr_chan_s chan_cfg_out
);

	// Scoped fields come from input 0 under the standard sequencer
	acccr_cfg_s src;

	always_comb
	begin
		src = advanced_seq_in ? own_cfg_in : base_cfg_in;
		chan_cfg_out.threshold_detect_enable = src.threshold_detect_enable;
		chan_cfg_out.pairing_select          = src.pairing_select;
		chan_cfg_out.hiz_enable              = src.hiz_enable;
		chan_cfg_out.osr_select              = src.osr_select;
		chan_cfg_out.polarity                = own_cfg_in.polarity;
	end

endmodule

// File: hdl/acccr_regs.sv
// Behaviour
// - Input pin level read at bit 4.
// - Output field bit 0 drives pin.
// - Temperature sensor sequenced only while bit set.
// - Standard mode: input 0 enable governs all.
// - Advanced mode: each input own enable.
// - Alert flags pass only when detection enabled.
// - Polarity always from own register.
// - Standard mode: input 0 pairing for all.
// - Advanced mode: own pairing per input.
// - Pairing codes: ground, common, neighbour, invalid.
// - Sixteen config registers, 0x030 to 0x03F.
// - Output drives only if enabled, unclaimed.
// - Input reflects pin only if enabled, unclaimed.
`timescale 1ns/1ps
module acccr_regs
	import acccr_pkg::*;
(
	input  wire logic                    core_clk_in,
	input  wire logic                    rst_in,
	input  wire logic [ADDR_W-1:0]       addr_in,
	input  wire logic [DATA_W-1:0]       wr_data_in,
	input  wire logic                    wr_en_in,
	input  wire logic                    rd_en_in,
	output      logic [DATA_W-1:0]       rd_data_out,
	input  wire logic                    advanced_seq_in,
	input  wire logic                    pin_claimed_in,
	input  wire logic                    multifunction_pin_in,
	output      logic                    multifunction_pin_out,
	output      logic                    multifunction_pin_oe_out,
	input  wire logic [N_IN-1:0]         high_alert_raw_in,
	input  wire logic [N_IN-1:0]         low_alert_raw_in,
	output      logic [N_IN-1:0]         high_alert_flag_out,
	output      logic [N_IN-1:0]         low_alert_flag_out,
	output      logic                    temp_include_out,
	output      acccr_chan_s [N_IN-1:0]  chan_cfg_out,
	output      logic                    irq_out
);

	acccr_cfg_s                cfg_q [N_IN];
	acccr_chan_s [N_IN-1:0]    chan_eff;
	acccr_chan_s [N_IN-1:0]    chan_q;
	logic [DATA_W-1:0]         pin_ctrl_q;
	logic [GPO_FIELD_W-1:0]    output_pin_drive_field_q;
	logic                      input_pin_state_q;
	logic                      temp_include_q;
	logic                      pin_out_q;
	logic                      pin_oe_q;
	logic [N_IN-1:0]           high_flag_d;
	logic [N_IN-1:0]           low_flag_d;
	logic [N_IN-1:0]           high_flag_q;
	logic [N_IN-1:0]           low_flag_q;
	logic [IRQ_W-1:0]          status_q;
	logic [IRQ_W-1:0]          status_d;
	logic [IRQ_W-1:0]          mask_q;
	logic [IRQ_W-1:0]          event_d;
	logic [IRQ_W-1:0]          clear_d;
	logic                      irq_q;
	logic [DATA_W-1:0]         rd_d;
	logic [DATA_W-1:0]         rd_q;
	logic [ADDR_W-1:0]         cfg_ofs;
	logic [3:0]                cfg_idx;
	logic                      cfg_hit;
	logic                      cfg_wr;
	logic                      gpi_active;
	logic                      gpo_active;

	// Address decode for the per-input bank
	assign cfg_ofs = addr_in - CFG_BASE_OFS;
	assign cfg_idx = cfg_ofs[3:0];
	assign cfg_hit = (addr_in >= CFG_BASE_OFS) && (addr_in <= CFG_LAST_OFS);
	assign cfg_wr  = wr_en_in && cfg_hit;

	// Pin ownership: busy and alert functions outrank the plain pin modes
	assign gpo_active = pin_ctrl_q[OUT_FN_EN_BIT] && !pin_claimed_in;
	assign gpi_active = pin_ctrl_q[IN_FN_EN_BIT] && !pin_claimed_in;

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < N_IN; i++)
			begin
				cfg_q[i] <= CFG_RESET;
			end
		end
		else if (cfg_wr)
		begin
			// Stride of one, so the offset is the index
			cfg_q[cfg_idx] <= wr_data_in & CFG_WMASK;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pin_ctrl_q <= PIN_CTRL_RESET;
		end
		else if (wr_en_in && addr_in == PIN_CTRL_OFS)
		begin
			pin_ctrl_q <= wr_data_in & PIN_CTRL_WMASK;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			output_pin_drive_field_q <= PIN_STATE_RESET[GPO_FIELD_LSB +: GPO_FIELD_W];
		end
		else if (wr_en_in && addr_in == PIN_STATE_OFS)
		begin
			// Upper nibble is the read-only input field
			output_pin_drive_field_q <= wr_data_in[GPO_FIELD_LSB +: GPO_FIELD_W];
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			temp_include_q <= TEMP_CTRL_RESET[TEMP_EN_BIT];
		end
		else if (wr_en_in && addr_in == TEMP_CTRL_OFS)
		begin
			temp_include_q <= wr_data_in[TEMP_EN_BIT];
		end
	end

	// Pin drive; only bit 0 of the drive field matters
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pin_out_q <= 1'b0;
			pin_oe_q  <= 1'b0;
		end
		else
		begin
			pin_oe_q  <= gpo_active;
			pin_out_q <= gpo_active && output_pin_drive_field_q[0];
		end
	end

	// Pin sample; reads zero whenever the input function is not in force
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			input_pin_state_q <= 1'b0;
		end
		else
		begin
			input_pin_state_q <= gpi_active && multifunction_pin_in;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < N_IN; gi++)
		begin : g_chan
			acccr_chan_sel u_sel
			(
				.own_cfg_in      (cfg_q[gi]),
				.base_cfg_in     (cfg_q[0]),
				.advanced_seq_in (advanced_seq_in),
				.chan_cfg_out    (chan_eff[gi])
			);

			// Comparator results are masked, not merely hidden from software
			assign high_flag_d[gi] = high_alert_raw_in[gi]
				&& chan_eff[gi].threshold_detect_enable;
			assign low_flag_d[gi]  = low_alert_raw_in[gi]
				&& chan_eff[gi].threshold_detect_enable;

			always_ff @(posedge core_clk_in or posedge rst_in)
			begin
				if (rst_in)
				begin
					chan_q[gi]      <= CHAN_RESET;
					high_flag_q[gi] <= 1'b0;
					low_flag_q[gi]  <= 1'b0;
				end
				else
				begin
					chan_q[gi]      <= chan_eff[gi];
					high_flag_q[gi] <= high_flag_d[gi];
					low_flag_q[gi]  <= low_flag_d[gi];
				end
			end
		end
	endgenerate

	// Events feeding the sticky status bits
	always_comb
	begin
		event_d = '0;
		event_d[IRQ_GPI_BIT]  = gpi_active && (multifunction_pin_in != input_pin_state_q);
		event_d[IRQ_HIGH_BIT] = |(high_flag_d & ~high_flag_q);
		event_d[IRQ_LOW_BIT]  = |(low_flag_d & ~low_flag_q);
		// Code 3 is stored as written; software is told instead of being overridden
		event_d[IRQ_BAD_PAIR_BIT] = cfg_wr
			&& (acccr_pair_e'(wr_data_in[5:4]) == PAIR_INVALID);
	end

	always_comb
	begin
		clear_d = '0;
		if (wr_en_in && addr_in == IRQ_STATUS_OFS)
		begin
			clear_d = wr_data_in[IRQ_W-1:0];
		end
		// A new event outweighs a clear in the same cycle
		status_d = (status_q & ~clear_d) | event_d;
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			status_q <= IRQ_RESET;
		end
		else
		begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			mask_q <= IRQ_RESET;
		end
		else if (wr_en_in && addr_in == IRQ_MASK_OFS)
		begin
			mask_q <= wr_data_in[IRQ_W-1:0];
		end
	end

	// Registered output, so it trails status by one cycle
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= |(status_q & mask_q);
		end
	end

	// Read mux; unmapped addresses and reserved bits return zero
	always_comb
	begin
		rd_d = '0;
		if (cfg_hit)
		begin
			rd_d = cfg_q[cfg_idx];
		end
		else
		begin
			unique case (addr_in)
				PIN_CTRL_OFS:
				begin
					rd_d = pin_ctrl_q;
				end
				PIN_STATE_OFS:
				begin
					rd_d[GPI_FIELD_LSB] = input_pin_state_q;
					rd_d[GPO_FIELD_LSB +: GPO_FIELD_W] = output_pin_drive_field_q;
				end
				TEMP_CTRL_OFS:
				begin
					rd_d[TEMP_EN_BIT] = temp_include_q;
				end
				IRQ_STATUS_OFS:
				begin
					rd_d[IRQ_W-1:0] = status_q;
				end
				IRQ_MASK_OFS:
				begin
					rd_d[IRQ_W-1:0] = mask_q;
				end
				default:
				begin
					rd_d = '0;
				end
			endcase
		end
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rd_q <= '0;
		end
		else if (rd_en_in)
		begin
			rd_q <= rd_d;
		end
		else
		begin
			rd_q <= '0;
		end
	end

	assign rd_data_out              = rd_q;
	assign multifunction_pin_out    = pin_out_q;
	assign multifunction_pin_oe_out = pin_oe_q;
	assign high_alert_flag_out      = high_flag_q;
	assign low_alert_flag_out       = low_flag_q;
	assign temp_include_out         = temp_include_q;
	assign chan_cfg_out             = chan_q;
	assign irq_out                  = irq_q;

endmodule

// File: sim/acccr_regs_chk.sv
`timescale 1ns/1ps
module acccr_regs_chk
	import acccr_pkg::*;
(
	input wire logic			core_clk_in,
	input wire logic			rst_in,
	input wire logic [ADDR_W-1:0]		addr_in,
	input wire logic [DATA_W-1:0]		wr_data_in,
	input wire logic			wr_en_in,
	input wire logic			rd_en_in,
	input wire logic [DATA_W-1:0]		rd_data_out,
	input wire logic			advanced_seq_in,
	input wire logic			pin_claimed_in,
	input wire logic			multifunction_pin_out,
	input wire logic			multifunction_pin_oe_out,
	input wire logic [N_IN-1:0]		high_alert_raw_in,
	input wire logic [N_IN-1:0]		low_alert_raw_in,
	input wire logic [N_IN-1:0]		high_alert_flag_out,
	input wire logic [N_IN-1:0]		low_alert_flag_out,
	input wire logic			temp_include_out,
	input wire acccr_chan_s [N_IN-1:0]	chan_cfg_out
);
	logic [N_IN-1:0]	td_vec;
	logic [N_IN-1:0]	pair_ok;
	always_comb
	begin
		for (int i = 0; i < N_IN; i++)
		begin
			td_vec[i] = chan_cfg_out[i].threshold_detect_enable;
			pair_ok[i] = chan_cfg_out[i].pairing_select == chan_cfg_out[0].pairing_select;
		end
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// Mode must hold two edges: settings lag a mode change by one
	sequence std_steady;
		!advanced_seq_in && $past(!advanced_seq_in);
	endsequence
	sequence temp_write;
		wr_en_in && addr_in == TEMP_CTRL_OFS;
	endsequence
	chk_temp_follow: assert property (temp_write |=>
		temp_include_out == $past(wr_data_in[TEMP_EN_BIT]))
		else $error("temp include wrong");
	chk_std_enable: assert property (std_steady |-> td_vec == '0 || td_vec == '1)
		else $error("standard enable not shared");
	chk_std_pairing: assert property (std_steady |-> &pair_ok)
		else $error("standard pairing not shared");
	chk_high_gate: assert property (high_alert_flag_out == ($past(high_alert_raw_in) & td_vec))
		else $error("high flag not gated");
	chk_low_gate: assert property (low_alert_flag_out == ($past(low_alert_raw_in) & td_vec))
		else $error("low flag not gated");
	chk_drive_gate: assert property (multifunction_pin_oe_out |-> $past(!pin_claimed_in))
		else $error("pin driven while claimed");
	chk_drive_idle: assert property (!multifunction_pin_oe_out |-> !multifunction_pin_out)
		else $error("pin value without enable");
	chk_rsvd_zero: assert property (rd_en_in && addr_in == TEMP_CTRL_OFS |=> rd_data_out[7:1] == 0)
		else $error("reserved bits not zero");
endmodule
bind acccr_regs acccr_regs_chk u_acccr_regs_chk (.*);

// File: sim/test_adc_channel_config_regs.sv
`timescale 1ns/1ps
module test_adc_channel_config_regs import acccr_pkg::*;;
	logic			core_clk_in = 1'h0;
	logic			rst_in = 1'h1;
	logic [ADDR_W-1:0]	addr_in = '0;
	logic [DATA_W-1:0]	wr_data_in = '0;
	logic			wr_en_in = 1'h0;
	logic			rd_en_in = 1'h0;
	logic			advanced_seq_in = 1'h0;
	logic			pin_claimed_in = 1'h0;
	logic			multifunction_pin_in = 1'h0;
	logic [N_IN-1:0]	high_alert_raw_in = '0;
	logic [N_IN-1:0]	low_alert_raw_in = '0;
	logic [DATA_W-1:0]	rd_data_out;
	logic			multifunction_pin_out;
	logic			multifunction_pin_oe_out;
	logic			temp_include_out;
	logic			irq_out;
	logic [N_IN-1:0]	high_alert_flag_out;
	logic [N_IN-1:0]	low_alert_flag_out;
	acccr_chan_s [N_IN-1:0]	chan_cfg_out;
	int			mismatches = 0;
	int			tests_run = 0;
	int			cyc = 0;
	acccr_regs u_acccr_regs (.*);
	always #10 core_clk_in = ~core_clk_in;
	task automatic close_out;
		$display("tests %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge core_clk_in)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			mismatches++;
			close_out;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
		// Return on an edge so callers drive inputs there
		@(posedge core_clk_in);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		wr_en_in <= 1'h1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge core_clk_in);
		wr_en_in <= 1'h0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string what);
		@(posedge core_clk_in);
		rd_en_in <= 1'h1;
		addr_in <= a;
		@(posedge core_clk_in);
		rd_en_in <= 1'h0;
		#1;
		chk(16'(rd_data_out), 16'(e), what);
	endtask
	// Registered outputs lag a write by up to two edges
	task automatic settle;
		repeat (3) @(posedge core_clk_in);
		#1;
	endtask
	task automatic t_reset;
		rd(PIN_CTRL_OFS, 8'h00, "ctrl");
		rd(PIN_STATE_OFS, 8'h00, "state");
		rd(TEMP_CTRL_OFS, 8'h00, "temp");
		for (int i = 0; i < N_IN; i++)
			rd(12'h030 + 12'(i), 8'h08, "cfg");
		rd(12'h040, 8'h00, "unmapped");
		$display("t_reset done");
	endtask
	task automatic t_access;
		wr(TEMP_CTRL_OFS, 8'hFF);
		rd(TEMP_CTRL_OFS, 8'h01, "temp ro");
		chk(16'(temp_include_out), 16'h0001, "temp on");
		wr(TEMP_CTRL_OFS, 8'h00);
		settle;
		chk(16'(temp_include_out), 16'h0000, "temp off");
		wr(CFG_LAST_OFS, 8'hE7);
		rd(CFG_LAST_OFS, 8'hE3, "cfg ro");
		wr(CFG_LAST_OFS, 8'h08);
		wr(PIN_STATE_OFS, 8'hFF);
		rd(PIN_STATE_OFS, 8'h0F, "state ro");
		$display("t_access done");
	endtask
	task automatic t_pin;
		multifunction_pin_in <= 1'h1;
		wr(PIN_CTRL_OFS, 8'h11);
		wr(PIN_STATE_OFS, 8'h01);
		settle;
		chk(16'({multifunction_pin_oe_out, multifunction_pin_out}), 16'h3, "drive");
		rd(PIN_STATE_OFS, 8'h11, "gpi");
		wr(PIN_STATE_OFS, 8'h02);
		settle;
		chk(16'({multifunction_pin_oe_out, multifunction_pin_out}), 16'h2, "bit0");
		pin_claimed_in <= 1'h1;
		settle;
		chk(16'(multifunction_pin_oe_out), 16'h0, "claimed");
		rd(PIN_STATE_OFS, 8'h02, "gpi claimed");
		pin_claimed_in <= 1'h0;
		wr(PIN_CTRL_OFS, 8'h00);
		$display("t_pin done");
	endtask
	task automatic t_thresh;
		high_alert_raw_in <= 16'hFFFF;
		low_alert_raw_in <= 16'hFFFF;
		wr(CFG_BASE_OFS, 8'hA8);
		wr(12'h035, 8'h48);
		wr(12'h039, 8'h98);
		settle;
		chk(high_alert_flag_out, 16'hFFFF, "std td");
		chk(16'(chan_cfg_out[7].pairing_select), 16'h2, "std pair");
		chk(16'({chan_cfg_out[5].polarity, chan_cfg_out[0].polarity}), 16'h2, "pol");
		advanced_seq_in <= 1'h1;
		settle;
		chk(low_alert_flag_out, 16'h0201, "adv td");
		chk(16'(chan_cfg_out[9].pairing_select), 16'h1, "adv pair");
		chk(16'(chan_cfg_out[7].pairing_select), 16'h0, "adv own");
		// Invalid code never written
		for (int c = 0; c < 3; c++)
		begin
			wr(12'h033, {2'h0, 2'(c), 4'h8});
			settle;
			chk(16'(chan_cfg_out[3].pairing_select), 16'(c), "codes");
		end
		$display("t_thresh done");
	endtask
	// Status bit 1 fires on a rising gated high flag
	task automatic t_irq;
		wr(IRQ_MASK_OFS, 8'h02);
		wr(IRQ_STATUS_OFS, 8'h0F);
		high_alert_raw_in <= 16'h0000;
		settle;
		chk(16'(irq_out), 16'h0, "irq idle");
		high_alert_raw_in <= 16'h0001;
		settle;
		chk(16'(irq_out), 16'h1, "irq set");
		rd(IRQ_STATUS_OFS, 8'h02, "status");
		wr(IRQ_STATUS_OFS, 8'h02);
		settle;
		chk(16'(irq_out), 16'h0, "irq clear");
		wr(IRQ_MASK_OFS, 8'h00);
		high_alert_raw_in <= 16'h0000;
		repeat (3) @(posedge core_clk_in);
		high_alert_raw_in <= 16'h0001;
		settle;
		chk(16'(irq_out), 16'h0, "irq masked");
		rd(IRQ_STATUS_OFS, 8'h02, "masked status");
		wr(IRQ_STATUS_OFS, 8'h0F);
		low_alert_raw_in <= 16'h0000;
		repeat (3) @(posedge core_clk_in);
		low_alert_raw_in <= 16'h0001;
		settle;
		rd(IRQ_STATUS_OFS, 8'h04, "low status");
		wr(PIN_CTRL_OFS, 8'h10);
		settle;
		rd(IRQ_STATUS_OFS, 8'h05, "pin change");
		rd(PIN_STATE_OFS, 8'h12, "gpi level");
		$display("t_irq done");
	endtask
	initial
	begin
		repeat (10) @(posedge core_clk_in);
		rst_in <= 1'h0;
		t_reset;
		t_access;
		t_pin;
		t_thresh;
		t_irq;
		close_out;
	end
endmodule
